// ===== hw/clk_ctrl_pkg.sv
// Constants for the system clock divider, source select and bank 5 bus control.
// Assumes a single 50 MHz register clock; the register sits on an Avalon-MM slave.
// Summary of operation
// - With the source select pin low the PLL output is the undivided internal clock.
// - With the source select pin high the external clock input is used directly.
// - In PLL mode the internal clock is the external clock times a fixed factor, 10 MHz gives 50 MHz.
// - The 16-bit divider field is one-hot and divides by the power of two of the set bit.
// - An all-zero divider field passes the undivided clock through unchanged.
// - The divided clock drives the processor core and all system peripherals.
// - Any division by two or more loses the 50 percent duty cycle; bit 0 set passes the clock unchanged.
// - With bank 5 wait enabled the wait request is sampled the cycle after chip select asserts.
// - The multiplex enable bit puts address and data on shared lines in separate phases.
// - The address phase field gives one, two or three bus clocks for codes 00, 01 and 10.
package clk_ctrl_pkg;
  localparam logic [15:0] CLOCK_DIVIDE_CONTROL_OFS = 16'h3000;
  localparam logic [31:0] CLOCK_DIVIDE_CONTROL_RST = 32'h00000000;
  localparam int          DIV_LSB                  = 0;
  localparam int          DIV_W                    = 16;
  localparam int          WAIT_EN_BIT              = 16;
  localparam int          MUX_EN_BIT               = 17;
  localparam int          ADDR_PHASE_LSB           = 18;
  localparam int          TEST_BIT                 = 31;
  localparam logic [31:0] WRITABLE_MASK            = 32'h800FFFFF;
  localparam int          PLL_MULTIPLY_FACTOR      = 5;
  localparam logic [31:0] UNMAPPED_READ            = 32'h00000000;
endpackage : clk_ctrl_pkg

// ===== hw/clk_pow2_divider.sv
// Power-of-two clock divider steered by a one-hot field.
// Assumes the divide field is stable or changes rarely; a change may give one odd period.
`timescale 1ns/1ps
`default_nettype none
module clk_pow2_divider #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         i_clk_in,
  input  wire logic         i_reset,
  // Control
  input  wire logic [W-1:0] i_divide_onehot,
  // Output
  output logic              o_clk_out
);
  logic [W-1:0] count_reg;
  logic         pulse_reg;

  // Elaboration check: the counter must be able to hold one full divided period.
  if (W < 2 || W > 32) begin : g_bad_width
    $error("divider width out of range");
  end

  // Free running counter; bit k toggles at the input rate divided by 2^(k+1).
  always_ff @(posedge i_clk_in or posedge i_reset) begin
    if (i_reset) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // One high phase per divided period: short pulses, so duty is not 50 percent.
  // Bit k set gives a mask of k low ones, so one input period in 2^k passes.
  // The enable moves on the falling edge, while the input is low, so gating it
  // with the input clock can neither clip a high phase nor make a runt pulse.
  always_ff @(negedge i_clk_in or posedge i_reset) begin
    if (i_reset) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= ((count_reg & (i_divide_onehot - {{(W-1){1'b0}}, 1'b1}))
                    == '0);
    end
  end

  // Bit 0 set divides by one; zero field passes the input untouched.
  assign o_clk_out = (i_divide_onehot == '0 || i_divide_onehot[0]) ? i_clk_in
                     : (pulse_reg & i_clk_in);
endmodule : clk_pow2_divider
`default_nettype wire

// ===== hw/clk_source_mux.sv
// Selects the undivided internal clock between PLL output and external input.
// Assumes the strap pin is static; no glitch protection is attempted on a live change.
`timescale 1ns/1ps
`default_nettype none
module clk_source_mux (
  // Clock sources
  input  wire logic i_pll_clk,
  input  wire logic i_external_clock_input,
  // Strap
  input  wire logic i_clock_source_select_pin,
  // Selected clock
  output logic      o_undivided_internal_clock
);
  // Strap high bypasses the PLL, strap low uses it.
  assign o_undivided_internal_clock = i_clock_source_select_pin ?
                                      i_external_clock_input :
                                      i_pll_clk;
endmodule : clk_source_mux
`default_nettype wire

// ===== hw/system_clock_divider_mux_ctrl.sv
// Clock control register with source select, divider and bank 5 mux-bus timing.
// Assumes an Avalon-MM master on i_clk and a bank 5 controller that starts cycles
// with a one-cycle pulse and reads back wait and phase results.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module system_clock_divider_mux_ctrl #(
  parameter int DIVIDER_WIDTH = clk_ctrl_pkg::DIV_W
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // Avalon-MM slave
  input  wire logic [15:0] i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  // Clock sources and strap
  input  wire logic        i_pll_clk,
  input  wire logic        i_external_clock_input,
  input  wire logic        i_clock_source_select_pin,
  output logic             o_undivided_internal_clock,
  output logic             o_system_clock,
  // Bank 5 bus
  input  wire logic        i_bank5_start,
  input  wire logic        i_external_wait_request_n,
  output logic             o_rom_chip_select_n,
  output logic             o_mux_enable,
  output logic             o_address_phase,
  output logic             o_wait_sampled,
  output logic             o_wait_active
);
  import clk_ctrl_pkg::*;

  // The block holds one control word at byte offset 0x3000.
  // Bits 15 to 0 hold the one-hot divide field; bit k divides by two to the power k.
  // Bit 16 enables wait sampling on bank 5.
  // Bit 17 enables the shared address and data lines on bank 5.
  // Bits 19 and 18 give the length code of the multiplexed address phase.
  // Bits 30 to 20 are not built; they read as zero and ignore writes.
  // Bit 31 is the factory test bit; it is stored and read back but drives nothing.
  // Every other offset reads as zero and swallows writes, so a stray access
  // by software cannot disturb the clock tree.

  // Bank 5 cycle states; the data phase is where wait can stretch the cycle.
  typedef enum logic [1:0] {B_IDLE, B_ADDR, B_DATA} bank_state_t;

  logic [31:0]        clock_divide_control_reg;
  logic               ack_reg;
  logic [31:0]        readdata_reg;
  bank_state_t        bstate_reg;
  logic [1:0]         phase_cnt_reg;
  logic               cs_first_reg;
  logic               wait_sampled_reg;
  logic               wait_active_reg;
  logic               hit;
  logic               req;
  logic               take;
  logic [DIV_W-1:0]   divide_field;
  logic               wait_enable;
  logic               mux_enable;
  logic [1:0]         phase_code;
  logic               wait_low;
  logic               data_hold;

  // Elaboration checks: the field layout must fit the word and the write mask.
  // A mismatch here would leave a control bit that software cannot reach.
  if (DIVIDER_WIDTH != DIV_W) begin : g_bad_width
    $error("divider field is fixed at 16 bits");
  end
  if (ADDR_PHASE_LSB + 2 > TEST_BIT) begin : g_bad_layout
    $error("address phase field overlaps the test bit");
  end
  if (WRITABLE_MASK[DIV_LSB +: DIV_W] != {DIV_W{1'b1}}) begin : g_bad_div_mask
    $error("divide field is not fully writable");
  end
  if (!WRITABLE_MASK[WAIT_EN_BIT] || !WRITABLE_MASK[MUX_EN_BIT]) begin : g_bad_bank_mask
    $error("bank 5 enable bits are not writable");
  end
  if (WRITABLE_MASK[ADDR_PHASE_LSB +: 2] != 2'h3) begin : g_bad_phase_mask
    $error("address phase field is not writable");
  end

  // Byte-lane merge of a write, honouring only implemented bits.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & WRITABLE_MASK;
    return (old & ~m) | (wd & m);
  endfunction : merge

  // Address phase length in bus clocks minus one; code 11 behaves as 10.
  function automatic logic [1:0] phase_len(input logic [1:0] code);
    return (code == 2'h3) ? 2'h2 : code;
  endfunction : phase_len

  assign hit = (i_address == CLOCK_DIVIDE_CONTROL_OFS);

  // Named views of the register fields keep the control logic readable.
  assign divide_field = clock_divide_control_reg[DIV_LSB +: DIV_W];
  assign wait_enable  = clock_divide_control_reg[WAIT_EN_BIT];
  assign mux_enable   = clock_divide_control_reg[MUX_EN_BIT];
  assign phase_code   = clock_divide_control_reg[ADDR_PHASE_LSB +: 2];

  // Bus timing, seen from the master:
  // In the first cycle of a request waitrequest is high and read data is loaded.
  // In the second cycle waitrequest is low; the edge that closes it takes the access.
  // A write lands on that same edge, never earlier, so an access that the master
  // would abandon cannot change the clock.
  // The master may start a new request in the very next cycle.
  // The cost is one wait state on every access, traded for flopped read data.
  assign req  = i_read | i_write;
  assign take = req & ack_reg;

  // Every access is answered with one wait state, so read data comes from a flop.
  assign o_waitrequest = req & ~ack_reg;

  // Acknowledge toggles once per request, so it never stays high for two cycles.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // Register write; software keeps the test bit at zero, it is stored but unused.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      clock_divide_control_reg <= CLOCK_DIVIDE_CONTROL_RST;
    end else if (i_write && take && hit) begin
      clock_divide_control_reg <= merge(clock_divide_control_reg, i_writedata,
                                        i_byteenable);
    end
  end

  // Read data; unmapped addresses read as zero.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      readdata_reg <= 32'h00000000;
    end else if (i_read && !ack_reg) begin
      readdata_reg <= hit ? clock_divide_control_reg : UNMAPPED_READ;
    end
  end
  assign o_readdata = readdata_reg;

  // Source selection; the PLL multiplies the external reference by a fixed factor.
  clk_source_mux u_src (
    .i_pll_clk                  (i_pll_clk),
    .i_external_clock_input     (i_external_clock_input),
    .i_clock_source_select_pin  (i_clock_source_select_pin),
    .o_undivided_internal_clock (o_undivided_internal_clock)
  );

  // The divided clock is the one clock for core and peripherals.
  clk_pow2_divider #(
    .W (DIV_W)
  ) u_div (
    .i_clk_in        (o_undivided_internal_clock),
    .i_reset         (i_reset),
    .i_divide_onehot (divide_field),
    .o_clk_out       (o_system_clock)
  );

  // Bank 5 timeline, one line per clock:
  // Cycle 0 carries the start pulse while chip select is still high.
  // Cycle 1 is the first cycle with chip select low; wait is looked at as it ends.
  // When multiplexed, the address phase fills code plus one cycles from cycle 1, three for code 11.
  // The data phase follows and lasts one cycle unless wait holds it.
  // Chip select returns high in the cycle after the data phase ends.
  // A start pulse that arrives while a cycle runs is ignored, not queued.
  // Without multiplexing the data phase starts in cycle 1 itself, so the first
  // wait look must already be able to hold it there.

  // The data phase holds while wait is seen low: in the first select cycle when
  // wait is enabled, and afterwards as long as the pin stays low.
  assign wait_low  = !i_external_wait_request_n;
  assign data_hold = wait_low && (wait_active_reg || (cs_first_reg && wait_enable));

  // Bank 5 cycle: chip select, then address phase when multiplexed, then data.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      bstate_reg    <= B_IDLE;
      phase_cnt_reg <= 2'h0;
    end else begin
      case (bstate_reg)
        B_IDLE: begin
          if (i_bank5_start) begin
            if (mux_enable) begin
              bstate_reg    <= B_ADDR;
              phase_cnt_reg <= phase_len(phase_code);
            end else begin
              bstate_reg <= B_DATA;
            end
          end
        end
        B_ADDR: begin
          if (phase_cnt_reg == 2'h0) begin
            bstate_reg <= B_DATA;
          end else begin
            phase_cnt_reg <= phase_cnt_reg - 2'h1;
          end
        end
        B_DATA: begin
          if (!data_hold) begin
            bstate_reg <= B_IDLE;
          end
        end
        default: bstate_reg <= B_IDLE;
      endcase
    end
  end

  // Marks the first cycle after chip select goes active.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cs_first_reg <= 1'b0;
    end else begin
      cs_first_reg <= (bstate_reg == B_IDLE) && i_bank5_start;
    end
  end

  // Pulse that reports the first wait look, one cycle after it was made.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wait_sampled_reg <= 1'b0;
    end else begin
      wait_sampled_reg <= cs_first_reg && wait_enable;
    end
  end

  // Wait is first looked at in the cycle after chip select, then held while low.
  // Once the pin goes high the level drops and cannot come back in that cycle,
  // so a late glitch on the pin cannot stretch a finished access.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wait_active_reg <= 1'b0;
    end else begin
      if (bstate_reg == B_IDLE) begin
        wait_active_reg <= 1'b0;
      end else if (cs_first_reg && wait_enable) begin
        wait_active_reg <= wait_low;
      end else if (wait_active_reg) begin
        wait_active_reg <= wait_low;
      end
    end
  end

  // Status and strobe outputs come straight from state and control flops.

  assign o_rom_chip_select_n = (bstate_reg == B_IDLE);
  assign o_mux_enable        = mux_enable;
  assign o_address_phase     = (bstate_reg == B_ADDR);
  assign o_wait_sampled      = wait_sampled_reg;
  assign o_wait_active       = wait_active_reg;
endmodule : system_clock_divider_mux_ctrl
`default_nettype wire

// ===== verif/clk_ctrl_props.sv
// Checker for the clock control block, watching only top-level ports.
// Assumes full-lane register writes and binding onto the top module.
`timescale 1ns/1ps
`default_nettype none
module clk_ctrl_props (
  // Watched ports
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic [15:0] i_address,
  input wire logic        i_write,
  input wire logic [31:0] i_writedata,
  input wire logic        o_waitrequest,
  input wire logic        i_pll_clk,
  input wire logic        i_external_clock_input,
  input wire logic        i_clock_source_select_pin,
  input wire logic        o_undivided_internal_clock,
  input wire logic        o_system_clock,
  input wire logic        o_rom_chip_select_n,
  input wire logic        o_address_phase,
  input wire logic        o_wait_sampled,
  input wire logic        o_mux_enable
);
  logic [15:0] div_reg;
  logic        wr_ok;
  assign wr_ok = i_write && !o_waitrequest && i_address == 16'h3000;
  // Mirror of the divide field, so the pass-through case can be judged.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) div_reg <= 16'h0000;
    else if (wr_ok) div_reg <= i_writedata[15:0];
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_pll_source: assert property (
    !i_clock_source_select_pin |-> o_undivided_internal_clock == i_pll_clk)
    else $error("pll clock not selected");
  a_ext_source: assert property (
    i_clock_source_select_pin |-> o_undivided_internal_clock == i_external_clock_input)
    else $error("external clock not selected");
  a_undivided_pass: assert property (
    div_reg == 16'h0000 |-> o_system_clock == o_undivided_internal_clock)
    else $error("zero field does not pass clock");
  a_wait_sample: assert property (
    o_wait_sampled |-> !$past(o_rom_chip_select_n) && $past(o_rom_chip_select_n, 2))
    else $error("wait sampled in wrong cycle");
  a_phase_max: assert property (
    o_address_phase [*3] |=> !o_address_phase) else $error("address phase too long");
  a_phase_in_cs: assert property (
    o_address_phase |-> !o_rom_chip_select_n) else $error("address phase without select");
  a_mux_bit: assert property (
    wr_ok |=> o_mux_enable == $past(i_writedata[17])) else $error("mux enable wrong");
  a_phase_start: assert property (
    $fell(o_rom_chip_select_n) && o_mux_enable |-> o_address_phase)
    else $error("address phase late");
endmodule : clk_ctrl_props
bind system_clock_divider_mux_ctrl clk_ctrl_props i_props (.i_clk, .i_reset, .i_address,
  .i_write, .i_writedata, .o_waitrequest, .i_pll_clk, .i_external_clock_input,
  .i_clock_source_select_pin, .o_undivided_internal_clock, .o_system_clock,
  .o_rom_chip_select_n, .o_address_phase, .o_wait_sampled, .o_mux_enable);
`default_nettype wire

// ===== verif/clk_ext_partner.sv
// External clock source and a slow multiplexed-bus device on bank 5.
// Assumes the bench sets how many select cycles the device holds wait.
`timescale 1ns/1ps
`default_nettype none
module clk_ext_partner (
  input  wire logic       i_clk,
  input  wire logic       i_cs_n,
  input  wire logic [3:0] i_hold,
  output logic            o_ext_clk,
  output logic            o_pll_clk,
  output logic            o_wait_n
);
  logic [3:0] cnt;
  // 10 MHz reference and its times-five product, offset so no edge meets i_clk.
  initial begin o_ext_clk = 1'b0; #1; forever #50 o_ext_clk = ~o_ext_clk; end
  initial begin o_pll_clk = 1'b0; #3; forever #10 o_pll_clk = ~o_pll_clk; end
  always @(posedge i_clk) cnt <= i_cs_n ? 4'h0 : cnt + 4'h1;
  // Wait shows from the first select cycle; pulled up when not selected.
  assign o_wait_n = i_cs_n | (cnt >= i_hold);
endmodule : clk_ext_partner
`default_nettype wire

// ===== verif/system_clock_divider_mux_ctrl_tb_top.sv
// Self-checking bench: register access, clock select, divider and bank 5 cycles.
// Assumes the partner model supplies both clocks and the wait line.
`timescale 1ns/1ps
`default_nettype none
module system_clock_divider_mux_ctrl_tb_top;
  import clk_ctrl_pkg::*;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, sel = 1'b1, start = 1'b0, ws, wa;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [3:0]  hold = 4'h0;
  wire  wreq, pll, ext, undiv, sclk, cs_n, mux, aph, wsmp, wact, wait_n;
  int   fails = 0, checks = 0, se = 0, ph, cs;
  always #10 clk = ~clk;
  always @(posedge sclk) se++;
  clk_ext_partner i_partner (.i_clk(clk), .i_cs_n(cs_n), .i_hold(hold), .o_ext_clk(ext),
    .o_pll_clk(pll), .o_wait_n(wait_n));
  system_clock_divider_mux_ctrl i_dut (.i_clk(clk), .i_reset(rst), .i_address(addr),
    .i_read(rd), .i_write(wr), .i_writedata(wdata), .i_byteenable(4'hF), .o_readdata(rdata),
    .o_waitrequest(wreq), .i_pll_clk(pll), .i_external_clock_input(ext),
    .i_clock_source_select_pin(sel), .o_undivided_internal_clock(undiv),
    .o_system_clock(sclk), .i_bank5_start(start), .i_external_wait_request_n(wait_n),
    .o_rom_chip_select_n(cs_n), .o_mux_enable(mux), .o_address_phase(aph),
    .o_wait_sampled(wsmp), .o_wait_active(wact));
  task automatic close_out();
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One bus access; the request is held until waitrequest is seen low.
  // Waitrequest is looked at mid-cycle, where it is settled; the next rising
  // edge is then the one that takes the access. The watchdog ends a hang.
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(negedge clk);
    while (wreq !== 1'b0) @(negedge clk);
    @(posedge clk);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : acc
  // Counts system clock edges over 64 undivided edges; phase allows one off.
  task automatic divrate(input logic [15:0] f, input int e);
    int s0;
    acc(1'b1, 16'h3000, {16'h0000, f});
    repeat (4) @(posedge undiv);
    s0 = se;
    repeat (64) @(posedge undiv);
    chk({31'h0, (se - s0 - e) * (se - s0 - e) <= 1}, 32'h1);
    @(posedge clk);
  endtask : divrate
  // One bank 5 cycle; tallies address phase and select cycles.
  task automatic bank(input logic [1:0] c, input logic en, input logic [3:0] h,
                      input logic m);
    acc(1'b1, 16'h3000, {12'h000, c, m, en, 16'h0000});
    hold <= h;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    ph = 0;
    cs = 0;
    ws = 1'b0;
    wa = 1'b0;
    repeat (12) begin @(negedge clk); ph += aph; cs += !cs_n; ws |= wsmp; wa |= wact; end
    @(posedge clk);
  endtask : bank
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    acc(1'b0, 16'h3000, 32'h0); chk(q, CLOCK_DIVIDE_CONTROL_RST);
    acc(1'b1, 16'h3000, 32'h7FFF0001);
    acc(1'b0, 16'h3000, 32'h0); chk(q, 32'h000F0001);
    chk({31'h0, mux}, 32'h1);
    acc(1'b1, 16'h3004, 32'hFFFF0001); acc(1'b0, 16'h3004, 32'h0); chk(q, 32'h0);
    for (int s = 0; s < 2; s++) begin
      sel <= s[0];
      repeat (3) @(posedge clk);
      repeat (16) begin #5; chk({31'h0, undiv}, {31'h0, s ? ext : pll}); end
      @(posedge clk);
    end
    for (int k = 0; k < 4; k++) divrate(16'h1 << k, 64 >> k);
    divrate(16'h0000, 64);
    for (int c = 0; c < 4; c++) begin
      bank(c[1:0], 1'b1, 4'h0, 1'b1);
      chk(ph, c == 3 ? 3 : c + 1);
      chk(cs, ph + 1);
    end
    bank(2'b00, 1'b1, 4'h3, 1'b1); chk({31'h0, ws && cs > 2}, 32'h1);
    chk({31'h0, wa}, 32'h1);
    bank(2'b00, 1'b0, 4'h3, 1'b1); chk({31'h0, ws}, 32'h0); chk(cs, 2);
    chk({31'h0, wa}, 32'h0);
    bank(2'b00, 1'b1, 4'h3, 1'b0); chk(cs, 4); chk(ph, 0);
    chk({31'h0, ws && wa}, 32'h1);
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule : system_clock_divider_mux_ctrl_tb_top
`default_nettype wire
